// ==== design/asa_baud_div.sv ====
`timescale 1ns/10ps
module asa_baud_div (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // crystal edge pulse, restart and divisor
    input wire logic crystalEdge,
    input wire logic restart,
    input wire logic [asa_pkg::DIV_W-1:0] divisor,
    // one-cycle 16x baud tick
    output logic tick
);

    typedef struct packed {
        logic [asa_pkg::DIV_W-1:0] cnt;
        logic tick;
    } asa_div_s;

    asa_div_s st_q;
    asa_div_s st_d;

    // compare with >= so a smaller divisor written mid-count cannot overrun
    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (restart) begin
            st_d.cnt = '0;
        end else if (crystalEdge) begin
            if (st_q.cnt >= divisor - 12'h001) begin
                st_d.cnt = '0;
                st_d.tick = 1'b1;
            end else begin
                st_d.cnt = st_q.cnt + 12'h001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;

endmodule

// ==== design/asa_pkg.sv ====
package asa_pkg;

    // register indices inside one adapter window (byte address = 4 * index)
    localparam logic [3:0] ADP_DATA_IDX = 4'h0;
    localparam logic [3:0] ADP_RESET_IDX = 4'h1;
    localparam logic [3:0] ADP_CMD_IDX = 4'h2;
    localparam logic [3:0] ADP_CTRL_IDX = 4'h3;

    // adapter window bases and shared registers, as word indices
    localparam logic [3:0] PORT_A_BASE_IDX = 4'h0;
    localparam logic [3:0] PORT_B_BASE_IDX = 4'h4;
    localparam logic [3:0] IRQ_STATUS_IDX = 4'h8;
    localparam logic [3:0] IRQ_MASK_IDX = 4'h9;
    localparam logic [3:0] EDGE_SEL_IDX = 4'hA;
    localparam logic [3:0] PIN_LEVEL_IDX = 4'hB;

    // values after hardware reset
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] IRQ_STATUS_RESET = 8'h00;
    localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
    localparam logic [7:0] EDGE_SEL_RESET = 8'h00;

    // program reset: command bits 4..0 clear, control bit 4 set
    localparam logic [7:0] CMD_PROG_RESET_KEEP = 8'hE0;
    localparam logic [7:0] CTRL_PROG_RESET_SET = 8'h10;

    // frame control field positions
    localparam int CTRL_STOP_BIT = 7;
    localparam int CTRL_WL_HI = 6;
    localparam int CTRL_WL_LO = 5;
    localparam int CTRL_RXCLK_BIT = 4;
    localparam int CTRL_RATE_HI = 3;
    localparam int CTRL_RATE_LO = 0;

    // command field positions
    localparam int CMD_PKIND_HI = 7;
    localparam int CMD_PKIND_LO = 6;
    localparam int CMD_PEN_BIT = 5;
    localparam int CMD_ECHO_BIT = 4;
    localparam int CMD_TXC_HI = 3;
    localparam int CMD_TXC_LO = 2;
    localparam int CMD_RXIRQ_DIS_BIT = 1;
    localparam int CMD_DTR_BIT = 0;

    // transmitter control codes
    localparam logic [1:0] TXC_RTS_HIGH = 2'h0;
    localparam logic [1:0] TXC_IRQ_ON = 2'h1;
    localparam logic [1:0] TXC_QUIET = 2'h2;
    localparam logic [1:0] TXC_BREAK = 2'h3;

    // stop bit codes presented to the shifters
    localparam logic [1:0] STOP_ONE = 2'h0;
    localparam logic [1:0] STOP_ONE_HALF = 2'h1;
    localparam logic [1:0] STOP_TWO = 2'h2;

    // oversampling: ticks per bit time
    localparam int BAUD_OVERSAMPLE = 16;
    localparam int DIV_W = 12;

    // baud crystal edges per 16x tick, 1.8432 MHz source, indexed by rate code
    localparam logic [DIV_W-1:0] BAUD_DIV [16] = '{
        12'h001, 12'h900, 12'h600, 12'h417, 12'h358, 12'h300, 12'h180, 12'h0C0,
        12'h060, 12'h040, 12'h030, 12'h020, 12'h018, 12'h010, 12'h00C, 12'h006
    };

    // top-level state
    typedef struct packed {
        logic [1:0][7:0] ctrl;
        logic [1:0][7:0] cmd;
        logic [7:0] irqStatus;
        logic [7:0] irqMask;
        logic [7:0] edgeSel;
        logic [31:0] rdata;
        logic [1:0] progReset;
        logic [1:0] rtsN;
        logic [1:0] txIrqEn;
        logic [1:0] rxIrqEn;
        logic [1:0] brk;
        logic [1:0] dtr;
        logic [1:0] parEn;
        logic [1:0][1:0] parKind;
        logic [1:0][3:0] dataBits;
        logic [1:0][1:0] stopCode;
        logic [1:0] rxClkSel;
        logic irq;
    } asa_regs_s;

endpackage

// ==== design/asa_sync_edge.sv ====
`timescale 1ns/10ps
module asa_sync_edge #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // pins and edge polarity (1 = rising)
    input wire logic [WIDTH-1:0] pinIn,
    input wire logic [WIDTH-1:0] risingSel,
    // synchronised level and edge pulse
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] edgePulse
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] prev;
    } asa_sync_s;

    asa_sync_s st_q;
    asa_sync_s st_d;

    // meta feeds only sync; edges are judged on sync against prev
    always_comb begin
        st_d = st_q;
        st_d.meta = pinIn;
        st_d.sync = st_q.meta;
        st_d.prev = st_q.sync;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level = st_q.sync;
    assign edgePulse = (risingSel & st_q.sync & ~st_q.prev)
                     | (~risingSel & ~st_q.sync & st_q.prev);

endmodule

// ==== design/asa_top.sv ====
// Behaviour
// - two identical independent serial adapters
// - baud rates divided from 1.8432 MHz input
// - baud clock separate from system clock
// - rate field in control bits 3..0
// - echo bit has no effect
// - transmitter field drives request-to-send and break
// - four handshake port pins per adapter
// - a handshake pin edge of the selected polarity raises interrupt when its mask bit is set
// - write offset one does program reset
`timescale 1ns/10ps
module asa_top (
    // system clock and reset
    input wire logic clk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // baud crystal input pin
    input wire logic baudCrystalInput,
    // handshake port pins, 3..0 port a, 7..4 port b
    input wire logic [7:0] handshakeIn,
    // handshake interrupt
    output logic handshakeIrq,
    // per-adapter configuration, index 0 port a, 1 port b
    output logic [1:0] requestToSendN,
    output logic [1:0] txIrqEnable,
    output logic [1:0] rxIrqEnable,
    output logic [1:0] sendBreak,
    output logic [1:0] dataTerminalReady,
    // frame format
    output logic [1:0] parityEnable,
    output logic [1:0][1:0] parityKind,
    output logic [1:0][3:0] dataBitCount,
    output logic [1:0][1:0] stopBitCode,
    output logic [1:0] receiverClockSelect,
    // baud tick and program reset pulses
    output logic [1:0] baudTick,
    output logic [1:0] programReset
);

    asa_pkg::asa_regs_s st_q;
    asa_pkg::asa_regs_s st_d;

    // synchronised crystal and handshake pin events
    logic crystalEdge;
    logic [7:0] pinLevel;
    logic [7:0] pinEdge;

    // apb decode
    logic [3:0] wordIdx;
    logic setupPhase;
    logic accessPhase;
    logic wrStrobe;
    logic mapped;

    // the baud crystal is foreign to clk, so it is synchronised and edge counted
    asa_sync_edge #(
        .WIDTH(1)
    ) u_crystal (
        .clk(clk),
        .reset(reset),
        .pinIn(baudCrystalInput),
        .risingSel(1'b1),
        .level(),
        .edgePulse(crystalEdge)
    );

    // handshake pins: edge polarity per pin from the edge select register
    asa_sync_edge #(
        .WIDTH(8)
    ) u_handshake (
        .clk(clk),
        .reset(reset),
        .pinIn(handshakeIn),
        .risingSel(st_q.edgeSel),
        .level(pinLevel),
        .edgePulse(pinEdge)
    );

    // one divider per adapter, both fed from the same crystal edges
    for (genvar p = 0; p < 2; p++) begin : g_port
        asa_baud_div u_div (
            .clk(clk),
            .reset(reset),
            .crystalEdge(crystalEdge),
            .restart(st_q.progReset[p]),
            .divisor(asa_pkg::BAUD_DIV[st_q.ctrl[p][asa_pkg::CTRL_RATE_HI:asa_pkg::CTRL_RATE_LO]]),
            .tick(baudTick[p])
        );
    end

    // apb decode; zero wait states, read data latched in the setup cycle
    assign wordIdx = paddr[5:2];
    assign setupPhase = psel & ~penable;
    assign accessPhase = psel & penable;
    assign wrStrobe = accessPhase & pwrite & mapped;

    // data register lives in the shifter block, so it answers with an error here
    always_comb begin
        mapped = 1'b0;
        if (paddr[1:0] == 2'h0 && paddr[7:6] == 2'h0) begin
            // offset one is mapped so that its write can fire a program reset
            case (wordIdx)
                asa_pkg::PORT_A_BASE_IDX + asa_pkg::ADP_RESET_IDX,
                asa_pkg::PORT_A_BASE_IDX + asa_pkg::ADP_CMD_IDX,
                asa_pkg::PORT_A_BASE_IDX + asa_pkg::ADP_CTRL_IDX,
                asa_pkg::PORT_B_BASE_IDX + asa_pkg::ADP_RESET_IDX,
                asa_pkg::PORT_B_BASE_IDX + asa_pkg::ADP_CMD_IDX,
                asa_pkg::PORT_B_BASE_IDX + asa_pkg::ADP_CTRL_IDX,
                asa_pkg::IRQ_STATUS_IDX,
                asa_pkg::IRQ_MASK_IDX,
                asa_pkg::EDGE_SEL_IDX,
                asa_pkg::PIN_LEVEL_IDX: begin
                    mapped = 1'b1;
                end
                default: begin
                    mapped = 1'b0;
                end
            endcase
        end
    end

    // next state of every register in the block
    always_comb begin
        logic [3:0] base;
        logic [7:0] cmdV;
        logic [7:0] ctrlV;
        logic [7:0] clearMask;
        logic [1:0] wordLen;
        logic [1:0] txCode;
        base = '0;
        cmdV = '0;
        ctrlV = '0;
        clearMask = '0;
        wordLen = '0;
        txCode = '0;
        st_d = st_q;
        // program reset is a one-cycle pulse, low unless a write fires it
        st_d.progReset = 2'b00;

        // read data captured at setup so prdata comes from a flop
        if (setupPhase) begin
            st_d.rdata = '0;
            case (wordIdx)
                asa_pkg::PORT_A_BASE_IDX + asa_pkg::ADP_CMD_IDX: begin
                    st_d.rdata = {24'h000000, st_q.cmd[0]};
                end
                asa_pkg::PORT_A_BASE_IDX + asa_pkg::ADP_CTRL_IDX: begin
                    st_d.rdata = {24'h000000, st_q.ctrl[0]};
                end
                asa_pkg::PORT_B_BASE_IDX + asa_pkg::ADP_CMD_IDX: begin
                    st_d.rdata = {24'h000000, st_q.cmd[1]};
                end
                asa_pkg::PORT_B_BASE_IDX + asa_pkg::ADP_CTRL_IDX: begin
                    st_d.rdata = {24'h000000, st_q.ctrl[1]};
                end
                asa_pkg::IRQ_STATUS_IDX: begin
                    st_d.rdata = {24'h000000, st_q.irqStatus};
                end
                asa_pkg::IRQ_MASK_IDX: begin
                    st_d.rdata = {24'h000000, st_q.irqMask};
                end
                asa_pkg::EDGE_SEL_IDX: begin
                    st_d.rdata = {24'h000000, st_q.edgeSel};
                end
                asa_pkg::PIN_LEVEL_IDX: begin
                    st_d.rdata = {24'h000000, pinLevel};
                end
                default: begin
                    st_d.rdata = '0;
                end
            endcase
        end

        // adapter register writes; a write to offset one is a program reset
        for (int p = 0; p < 2; p++) begin
            base = (p == 0) ? asa_pkg::PORT_A_BASE_IDX : asa_pkg::PORT_B_BASE_IDX;
            if (wrStrobe && wordIdx == base + asa_pkg::ADP_CMD_IDX) begin
                st_d.cmd[p] = pwdata[7:0];
            end
            if (wrStrobe && wordIdx == base + asa_pkg::ADP_CTRL_IDX) begin
                st_d.ctrl[p] = pwdata[7:0];
            end
            // frame shape and parity survive; command bits 4..0 drop and the receiver clock bit sets
            if (wrStrobe && wordIdx == base + asa_pkg::ADP_RESET_IDX) begin
                st_d.cmd[p] = st_q.cmd[p] & asa_pkg::CMD_PROG_RESET_KEEP;
                st_d.ctrl[p] = st_q.ctrl[p] | asa_pkg::CTRL_PROG_RESET_SET;
                st_d.progReset[p] = 1'b1;
            end
        end

        // mask and edge select are plain read/write registers
        if (wrStrobe && wordIdx == asa_pkg::IRQ_MASK_IDX) begin
            st_d.irqMask = pwdata[7:0];
        end
        if (wrStrobe && wordIdx == asa_pkg::EDGE_SEL_IDX) begin
            st_d.edgeSel = pwdata[7:0];
        end

        // write one to clear; a pin edge in the same cycle keeps its bit set
        if (wrStrobe && wordIdx == asa_pkg::IRQ_STATUS_IDX) begin
            clearMask = pwdata[7:0];
        end
        st_d.irqStatus = (st_q.irqStatus & ~clearMask) | pinEdge;

        // configuration decode, registered so the shifters see clean levels
        for (int p = 0; p < 2; p++) begin
            cmdV = st_d.cmd[p];
            ctrlV = st_d.ctrl[p];
            txCode = cmdV[asa_pkg::CMD_TXC_HI:asa_pkg::CMD_TXC_LO];
            wordLen = ctrlV[asa_pkg::CTRL_WL_HI:asa_pkg::CTRL_WL_LO];
            case (txCode)
                asa_pkg::TXC_RTS_HIGH: begin
                    st_d.rtsN[p] = 1'b1;
                    st_d.txIrqEn[p] = 1'b0;
                    st_d.brk[p] = 1'b0;
                end
                asa_pkg::TXC_IRQ_ON: begin
                    st_d.rtsN[p] = 1'b0;
                    st_d.txIrqEn[p] = 1'b1;
                    st_d.brk[p] = 1'b0;
                end
                asa_pkg::TXC_QUIET: begin
                    st_d.rtsN[p] = 1'b0;
                    st_d.txIrqEn[p] = 1'b0;
                    st_d.brk[p] = 1'b0;
                end
                default: begin
                    st_d.rtsN[p] = 1'b0;
                    st_d.txIrqEn[p] = 1'b0;
                    st_d.brk[p] = 1'b1;
                end
            endcase
            st_d.rxIrqEn[p] = ~cmdV[asa_pkg::CMD_RXIRQ_DIS_BIT];
            st_d.dtr[p] = cmdV[asa_pkg::CMD_DTR_BIT];
            // the echo bit is stored for read-back only, nothing consumes it
            st_d.parEn[p] = cmdV[asa_pkg::CMD_PEN_BIT];
            st_d.parKind[p] = cmdV[asa_pkg::CMD_PKIND_HI:asa_pkg::CMD_PKIND_LO];
            st_d.dataBits[p] = 4'h8 - {2'b00, wordLen};
            // the stop select bit is qualified by word length and parity
            if (!ctrlV[asa_pkg::CTRL_STOP_BIT]) begin
                st_d.stopCode[p] = asa_pkg::STOP_ONE;
            end else if (wordLen == 2'b11) begin
                st_d.stopCode[p] = asa_pkg::STOP_ONE_HALF;
            end else if (wordLen == 2'b00
                         && cmdV[asa_pkg::CMD_PEN_BIT]) begin
                st_d.stopCode[p] = asa_pkg::STOP_ONE;
            end else begin
                st_d.stopCode[p] = asa_pkg::STOP_TWO;
            end
            st_d.rxClkSel[p] = ctrlV[asa_pkg::CTRL_RXCLK_BIT];
        end

        // from the next-state copies so the line follows a mask write at once
        st_d.irq = |(st_d.irqStatus & st_d.irqMask);
    end

    // single register stage for all block state
    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= '0;
            st_q.cmd <= {asa_pkg::CMD_RESET, asa_pkg::CMD_RESET};
            st_q.ctrl <= {asa_pkg::CTRL_RESET, asa_pkg::CTRL_RESET};
            st_q.irqStatus <= asa_pkg::IRQ_STATUS_RESET;
            st_q.irqMask <= asa_pkg::IRQ_MASK_RESET;
            st_q.edgeSel <= asa_pkg::EDGE_SEL_RESET;
            // decoded outputs start as the decode of zero command and control
            st_q.rtsN <= 2'b11;
            st_q.rxIrqEn <= 2'b11;
            st_q.dataBits <= {4'h8, 4'h8};
        end else begin
            st_q <= st_d;
        end
    end

    // apb answer: always ready, error only on unmapped access
    assign pready = 1'b1;
    assign pslverr = accessPhase & ~mapped;
    assign prdata = st_q.rdata;

    // outputs straight from the state register
    assign handshakeIrq = st_q.irq;
    assign requestToSendN = st_q.rtsN;
    assign txIrqEnable = st_q.txIrqEn;
    assign rxIrqEnable = st_q.rxIrqEn;
    assign sendBreak = st_q.brk;
    assign dataTerminalReady = st_q.dtr;
    assign parityEnable = st_q.parEn;
    assign parityKind = st_q.parKind;
    assign dataBitCount = st_q.dataBits;
    assign stopBitCode = st_q.stopCode;
    assign receiverClockSelect = st_q.rxClkSel;
    assign programReset = st_q.progReset;

endmodule

// ==== test/asa_chk_sva.sv ====
`timescale 1ns/10ps
module asa_chk (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // apb requests
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    // configuration and event outputs
    input wire logic handshakeIrq,
    input wire logic [1:0] requestToSendN,
    input wire logic [1:0] txIrqEnable,
    input wire logic [1:0] rxIrqEnable,
    input wire logic [1:0] sendBreak,
    input wire logic [1:0][3:0] dataBitCount,
    input wire logic [1:0][1:0] stopBitCode,
    input wire logic [1:0] parityEnable,
    input wire logic [1:0] baudTick,
    input wire logic [1:0] programReset
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic wr, wCmd, wCtl, wRst;
    // port a writes; pready is tied high, so the access edge is the write edge
    assign wr = psel && penable && pwrite;
    assign wCmd = wr && paddr == 8'h08;
    assign wCtl = wr && paddr == 8'h0C;
    assign wRst = wr && paddr == 8'h04;
    // outputs are registered at the same edge as the register; the checks look two edges on
    a_rts_code: assert property (wCmd |-> ##2 requestToSendN[0] == ($past(pwdata[3:2], 2) == 2'h0))
        else $error("rts level wrong");
    a_tx_modes: assert property (wCmd |-> ##2 (sendBreak[0] == ($past(pwdata[3:2], 2) == 2'h3))
        && (txIrqEnable[0] == ($past(pwdata[3:2], 2) == 2'h1)))
        else $error("break or tx irq wrong");
    a_parity_on: assert property (wCmd |-> ##2 parityEnable[0] == $past(pwdata[5], 2))
        else $error("parity enable wrong");
    a_word_len: assert property (wCtl |-> ##2 dataBitCount[0] == 4'h8 - {2'h0, $past(pwdata[6:5], 2)})
        else $error("word length wrong");
    a_stop_one: assert property (wCtl && !pwdata[7] |-> ##2 stopBitCode[0] == 2'h0)
        else $error("stop code not one");
    a_stop_half: assert property (wCtl && pwdata[7] && pwdata[6:5] == 2'h3 |-> ##2 stopBitCode[0] == 2'h1)
        else $error("stop code not one and half");
    // one-cycle pulse, then the outputs decode the command low bits as cleared
    a_prog_reset: assert property (wRst |=> programReset[0] ##1 !programReset[0]
        ##1 (requestToSendN[0] && rxIrqEnable[0] && !sendBreak[0]))
        else $error("program reset wrong");
    a_port_apart: assert property (wCmd |=> $stable(requestToSendN[1])[*3])
        else $error("port b disturbed");
    // even the fastest rate needs one crystal edge, over ten system cycles
    a_tick_gap: assert property (baudTick[0] |=> !baudTick[0] [*8])
        else $error("ticks too close");
    a_irq_fall: assert property ($fell(handshakeIrq) |-> $past(wr) || $past(wr, 2))
        else $error("irq dropped without a write");
endmodule
bind asa_top asa_chk u_chk (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .handshakeIrq(handshakeIrq),
    .requestToSendN(requestToSendN), .txIrqEnable(txIrqEnable), .rxIrqEnable(rxIrqEnable),
    .sendBreak(sendBreak), .dataBitCount(dataBitCount), .stopBitCode(stopBitCode),
    .parityEnable(parityEnable), .baudTick(baudTick), .programReset(programReset));

// ==== test/asa_peer_model.sv ====
`timescale 1ns/10ps
module asa_peer_model (
    // system clock and requested pin levels
    input wire logic clk,
    input wire logic [7:0] pinReq,
    // crystal and handshake lines
    output logic baudCrystalInput,
    output logic [7:0] handshakeIn
);
    // free-running crystal, phase unrelated to clk
    initial begin
        baudCrystalInput = 1'b0;
        #7.3;
        forever #271.27 baudCrystalInput = ~baudCrystalInput;
    end
    // peer moves its lines a cycle after asked, four per port
    initial handshakeIn = 8'h00;
    always @(posedge clk) handshakeIn <= pinReq;
endmodule

// ==== test/tb.sv ====
`timescale 1ns/10ps
module tb;
    logic clk, reset, psel, penable, pwrite, pready, pslverr, rerr, handshakeIrq;
    logic baudCrystalInput;
    logic [7:0] paddr, handshakeIn, pinReq, b;
    logic [31:0] pwdata, prdata, rdat, d;
    logic [1:0] requestToSendN, txIrqEnable, sendBreak, parityEnable, baudTick, programReset;
    logic [1:0] rxIrqEnable, dataTerminalReady, receiverClockSelect;
    logic [1:0][1:0] parityKind, stopBitCode;
    logic [1:0][3:0] dataBitCount;
    logic [31:0] rs = 32'h4D4BD545;
    logic [7:0] mCmd[2], mCtl[2];
    int num_errors = 0;
    int checked = 0;
    int p, g, n;
    int bc[4] = '{0, 14, 15, 13};
    int bb[4] = '{115200, 9600, 19200, 7200};
    asa_top uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .baudCrystalInput(baudCrystalInput), .handshakeIn(handshakeIn),
        .handshakeIrq(handshakeIrq), .requestToSendN(requestToSendN),
        .txIrqEnable(txIrqEnable), .rxIrqEnable(rxIrqEnable), .sendBreak(sendBreak),
        .dataTerminalReady(dataTerminalReady), .parityEnable(parityEnable),
        .parityKind(parityKind), .dataBitCount(dataBitCount), .stopBitCode(stopBitCode),
        .receiverClockSelect(receiverClockSelect),
        .baudTick(baudTick), .programReset(programReset));
    asa_peer_model peer (.clk(clk), .pinReq(pinReq), .baudCrystalInput(baudCrystalInput),
        .handshakeIn(handshakeIn));
    // xorshift source, fixed start
    function logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    task chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // one apb transfer; request held until pready is seen at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] dv);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dv;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] dv);
        apb(1'b1, a, dv);
    endtask
    task rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    // decoded outputs against the model registers
    task outs(input int k);
        repeat (3) @(posedge clk);
        chk(requestToSendN[k], mCmd[k][3:2] == 2'h0);
        chk(txIrqEnable[k], mCmd[k][3:2] == 2'h1);
        chk(sendBreak[k], mCmd[k][3:2] == 2'h3);
        chk(parityEnable[k], mCmd[k][5]);
        chk(parityKind[k], mCmd[k][7:6]);
        chk(dataBitCount[k], 8 - mCtl[k][6:5]);
        chk(stopBitCode[k], !mCtl[k][7] ? 0 : mCtl[k][6:5] == 2'h3 ? 1
            : (mCtl[k][6:5] == 2'h0 && mCmd[k][5]) ? 0 : 2);
        chk(rxIrqEnable[k], !mCmd[k][1]);
        chk(dataTerminalReady[k], mCmd[k][0]);
        chk(receiverClockSelect[k], mCtl[k][4]);
    endtask
    // cycles between the second and third ticks after a rate change
    task gap(input int k);
        g = 0;
        repeat (2) begin
            @(posedge clk);
            while (baudTick[k] !== 1'b1) @(posedge clk);
        end
        @(posedge clk);
        while (baudTick[k] !== 1'b1) begin
            g++;
            @(posedge clk);
        end
        g++;
    endtask
    task finish_test();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // a hang costs far more than the fewer than two thousand cycles the run needs
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        finish_test();
    end
    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pinReq = 8'h00;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            mCmd[i] = 8'h00;
            mCtl[i] = 8'h00;
            rd(i ? 8'h1C : 8'h0C);
            chk(rdat, 32'h0);
            outs(i);
        end
        // every transmitter code and frame shape on both ports
        for (int i = 0; i < 16; i++) begin
            p = i % 2;
            b = p ? 8'h10 : 8'h00;
            d = rnd();
            d[3:2] = i[2:1];
            d[5] = i[0] ^ i[3];
            mCmd[p] = d[7:0];
            wr(b + 8'h08, d);
            d = rnd();
            d[7:5] = i[3:1];
            mCtl[p] = d[7:0];
            wr(b + 8'h0C, d);
            rd(b + 8'h08);
            chk(rdat, {24'h0, mCmd[p]});
            rd(b + 8'h0C);
            chk(rdat, {24'h0, mCtl[p]});
            outs(p);
        end
        for (int i = 0; i < 2; i++) begin
            b = i ? 8'h10 : 8'h00;
            wr(b + 8'h04, rnd());
            @(negedge clk);
            chk(programReset[i], 1'b1);
            mCmd[i] &= 8'hE0;
            mCtl[i] |= 8'h10;
            rd(b + 8'h04);
            chk(rdat, 32'h0);
            chk(rerr, 1'b0);
            chk(programReset[i], 1'b0);
            rd(b + 8'h08);
            chk(rdat, {24'h0, mCmd[i]});
            rd(b + 8'h0C);
            chk(rdat, {24'h0, mCtl[i]});
            outs(i);
        end
        rd(8'h00);
        chk(rerr, 1'b1);
        // tick period from the baud rate, sixteen ticks per bit
        for (int i = 0; i < 4; i++) begin
            p = i / 3;
            mCtl[p][3:0] = bc[i];
            wr(p ? 8'h1C : 8'h0C, {24'h0, mCtl[p]});
            gap(p);
            n = 1000000000 / (800 * bb[i]);
            chk(g >= n - 1 && g <= n + 2, 1'b1);
        end
        wr(8'h28, 32'h01);
        wr(8'h24, 32'h21);
        pinReq <= 8'h21;
        repeat (8) @(posedge clk);
        chk(handshakeIrq, 1'b1);
        rd(8'h20);
        chk(rdat, 32'h01);
        rd(8'h2C);
        chk(rdat, 32'h21);
        pinReq <= 8'h01;
        repeat (8) @(posedge clk);
        rd(8'h20);
        chk(rdat, 32'h21);
        wr(8'h24, 32'h0);
        repeat (3) @(posedge clk);
        chk(handshakeIrq, 1'b0);
        wr(8'h24, 32'h20);
        repeat (3) @(posedge clk);
        chk(handshakeIrq, 1'b1);
        wr(8'h20, 32'h20);
        repeat (3) @(posedge clk);
        chk(handshakeIrq, 1'b0);
        rd(8'h20);
        chk(rdat, 32'h01);
        finish_test();
    end
endmodule
